/* File: design/rps_top.sv */
// Reset sources, ready flag and PHY power-down control of the Ethernet controller
`timescale 1ns/10ps
module rps_top #(
	parameter int unsigned POR_CYCLES = rps_pkg::POR_CYCLES,
	parameter int unsigned PHY_RST_CYCLES = rps_pkg::PHY_RST_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HW_RESET_IN_N,
	input wire logic HOST_READ,
	input wire logic HOST_WRITE,
	input wire logic SOFT_RESET_WR,
	input wire logic PHY_RESET_WR,
	input wire logic PHY_BCR_RESET_WR,
	input wire logic SLEEP_WR,
	input wire logic WAKE_WR,
	input wire logic PHY_POWER_DOWN,
	input wire logic ED_POWER_DOWN_EN,
	input wire logic LINE_ENERGY,
	input wire logic ENERGY_IRQ_EN,
	input wire logic ENERGY_IRQ_CLR,
	output logic READY,
	output logic SOFT_RESET_BIT,
	output logic PHY_RESET_BIT,
	output logic PHY_BCR_RESET_BIT,
	output logic EEPROM_BUSY,
	output logic WRITE_ACCEPT,
	output logic RST_PLL,
	output logic RST_HOST_BUS_IFACE,
	output logic RST_SOFT_RESET_PRESERVED,
	output logic RST_MII,
	output logic RST_MAC,
	output logic RST_PHY,
	output logic MAC_ADDR_RELOAD,
	output logic STRAP_LATCH,
	output logic PHY_POWERED,
	output logic PHY_TX_EN,
	output logic ENERGY_PRESENT,
	output logic ENERGY_IRQ_FLAG,
	output logic HOST_IRQ
);

	// ****************************************
	// State record
	// ****************************************
	typedef struct packed {
		rps_pkg::rps_state_e st;
		logic por_go;
		logic first_rd;
		logic irq_flag;
		logic pdn;
		logic [2:0] hw_sync;
		logic hw_lvl;
		logic [2:0] en_sync;
		logic en_lvl;
		logic reload;
		logic strap;
	} rps_main_s;

	// Pin stages start at their idle levels, so no false edge follows reset
	localparam rps_main_s RESET_VAL = '{
		st: rps_pkg::ST_POR,
		por_go: 1'b0,
		first_rd: 1'b0,
		irq_flag: 1'b0,
		pdn: 1'b0,
		hw_sync: rps_pkg::SYNC_IDLE_HI,
		hw_lvl: 1'b1,
		en_sync: rps_pkg::SYNC_IDLE_LO,
		en_lvl: 1'b0,
		reload: 1'b0,
		strap: 1'b0
	};

	rps_main_s s_q;
	rps_main_s s_d;

	// ****************************************
	// Timers
	// ****************************************
	rps_tmr_if tmr [rps_pkg::TMR_NUM + 1] ();
	logic [rps_pkg::TMR_NUM:0] t_start;
	logic [rps_pkg::TMR_NUM:0] t_busy;
	logic [rps_pkg::TMR_NUM:0] t_done;
	rps_pkg::rps_cnt_t t_len [rps_pkg::TMR_NUM + 1];
	localparam int TMR_EE_SLOT = rps_pkg::TMR_NUM;

	// Lengths of each timer
	assign t_len[rps_pkg::TMR_POR] = rps_pkg::rps_cnt_t'(POR_CYCLES);
	assign t_len[rps_pkg::TMR_SOFT_RESET_BIT] = rps_pkg::rps_cnt_t'(rps_pkg::SOFT_RESET_BIT_CYCLES);
	assign t_len[rps_pkg::TMR_PHYR] = rps_pkg::rps_cnt_t'(PHY_RST_CYCLES);
	assign t_len[rps_pkg::TMR_BCR] = rps_pkg::rps_cnt_t'(PHY_RST_CYCLES);
	assign t_len[rps_pkg::TMR_PDN] = rps_pkg::rps_cnt_t'(PHY_RST_CYCLES);
	assign t_len[rps_pkg::TMR_WAKE] = rps_pkg::rps_cnt_t'(rps_pkg::RESUME_CYCLES);
	assign t_len[TMR_EE_SLOT] = rps_pkg::rps_cnt_t'(rps_pkg::EE_CHECK_CYCLES);

	// One timer per sequenced interval
	for (genvar g = 0; g <= rps_pkg::TMR_NUM; g++) begin : g_tmr
		assign tmr[g].start = t_start[g];
		assign tmr[g].cycles = t_len[g];
		assign t_busy[g] = tmr[g].busy;
		assign t_done[g] = tmr[g].done;
		rps_timer u_tmr (
			.clk(CLK),
			.rst(RST),
			.t(tmr[g])
		);
	end

	// ****************************************
	// Decodes
	// ****************************************
	// True in states where every domain is held
	function automatic logic full_reset(input rps_pkg::rps_state_e st);
		full_reset = (st == rps_pkg::ST_POR) || (st == rps_pkg::ST_HWRST);
	endfunction

	// Two-stage agreement pin filter: the level moves once the two later stages agree
	function automatic logic pin_filter(input logic [2:0] sync, input logic lvl);
		pin_filter = (sync[1] == sync[2]) ? sync[2] : lvl;
	endfunction

	// Ready, write gate, energy edge and energy-detect power-down
	logic ready;
	logic wr_ok;
	logic en_rise;
	logic ed_down;

	// Ready only in run; writes further wait for the first read
	assign ready = (s_q.st == rps_pkg::ST_RUN);
	assign wr_ok = ready && s_q.first_rd;
	assign en_rise = pin_filter(s_q.en_sync, s_q.en_lvl) && !s_q.en_lvl;
	assign ed_down = ED_POWER_DOWN_EN && !s_q.en_lvl;

	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		t_start = '0;
		s_d.reload = 1'b0;
		s_d.strap = 1'b0;
		// Three-stage pin synchronisers; first stage feeds only the second
		s_d.hw_sync = {s_q.hw_sync[1:0], HW_RESET_IN_N};
		s_d.hw_lvl = pin_filter(s_q.hw_sync, s_q.hw_lvl);
		s_d.en_sync = {s_q.en_sync[1:0], LINE_ENERGY};
		s_d.en_lvl = pin_filter(s_q.en_sync, s_q.en_lvl);
		// A host read marks the first read after a reset or wake
		if (HOST_READ) begin
			s_d.first_rd = 1'b1;
		end
		case (s_q.st)
			rps_pkg::ST_POR: begin
				// First cycle after release loads the hold timer
				if (!s_q.por_go) begin
					s_d.por_go = 1'b1;
					t_start[rps_pkg::TMR_POR] = 1'b1;
				end else if (t_done[rps_pkg::TMR_POR]) begin
					s_d.st = rps_pkg::ST_RUN;
					s_d.reload = 1'b1;
					s_d.strap = 1'b1;
					t_start[TMR_EE_SLOT] = 1'b1;
				end
			end
			rps_pkg::ST_HWRST: begin
				// Released as soon as the filtered input returns high
				if (s_q.hw_lvl) begin
					s_d.st = rps_pkg::ST_RUN;
					s_d.reload = 1'b1;
					s_d.strap = 1'b1;
					t_start[TMR_EE_SLOT] = 1'b1;
				end
			end
			rps_pkg::ST_SOFT_RESET_BIT: begin
				// Domains stay held until the self-clearing bit drops
				if (t_done[rps_pkg::TMR_SOFT_RESET_BIT]) begin
					s_d.st = rps_pkg::ST_RUN;
					s_d.reload = 1'b1;
					t_start[TMR_EE_SLOT] = 1'b1;
				end
			end
			rps_pkg::ST_RUN: begin
				// Soft reset and sleep entries reopen the first-read gate
				if (SOFT_RESET_WR && wr_ok) begin
					s_d.st = rps_pkg::ST_SOFT_RESET_BIT;
					s_d.first_rd = HOST_READ;
					t_start[rps_pkg::TMR_SOFT_RESET_BIT] = 1'b1;
				end else if (SLEEP_WR && wr_ok) begin
					s_d.st = rps_pkg::ST_SLEEP;
					s_d.first_rd = HOST_READ;
				end
			end
			rps_pkg::ST_SLEEP: begin
				// Only the wake write is honoured while asleep
				if (WAKE_WR) begin
					s_d.st = rps_pkg::ST_WAKE;
					s_d.first_rd = HOST_READ;
					t_start[rps_pkg::TMR_WAKE] = 1'b1;
				end
			end
			rps_pkg::ST_WAKE: begin
				// Resume ends when the wake timer runs out
				if (t_done[rps_pkg::TMR_WAKE]) begin
					s_d.st = rps_pkg::ST_RUN;
				end
			end
			default: begin
				// An illegal code falls back to the power-on hold
				s_d.st = rps_pkg::ST_POR;
				s_d.por_go = 1'b0;
			end
		endcase
		// Hardware reset overrides all but the power-on hold
		if (!s_q.hw_lvl && (s_q.st != rps_pkg::ST_POR)) begin
			s_d.st = rps_pkg::ST_HWRST;
			s_d.first_rd = 1'b0;
		end
		// PHY-only resets, each from its own self-clearing bit
		// A write while running reloads the timer and lengthens the reset
		if (PHY_RESET_WR && wr_ok) begin
			t_start[rps_pkg::TMR_PHYR] = 1'b1;
		end
		if (PHY_BCR_RESET_WR && wr_ok) begin
			t_start[rps_pkg::TMR_BCR] = 1'b1;
		end
		// Leaving general power-down resets the PHY
		s_d.pdn = PHY_POWER_DOWN;
		if (s_q.pdn && !PHY_POWER_DOWN) begin
			t_start[rps_pkg::TMR_PDN] = 1'b1;
		end
		// Energy flag: the clear loses to a wake in the same cycle
		if (ENERGY_IRQ_CLR) begin
			s_d.irq_flag = 1'b0;
		end
		if (ED_POWER_DOWN_EN && en_rise) begin
			s_d.irq_flag = 1'b1;
		end
		if (full_reset(s_q.st)) begin
			s_d.irq_flag = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= RESET_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Status and reset outputs
	// ****************************************
	// Ready and the self-clearing bits follow the state and timers
	assign READY = ready;
	assign SOFT_RESET_BIT = t_busy[rps_pkg::TMR_SOFT_RESET_BIT];
	assign PHY_RESET_BIT = t_busy[rps_pkg::TMR_PHYR];
	assign PHY_BCR_RESET_BIT = t_busy[rps_pkg::TMR_BCR];
	assign EEPROM_BUSY = t_busy[TMR_EE_SLOT];
	assign WRITE_ACCEPT = HOST_WRITE && wr_ok;

	// Domain resets per source
	assign RST_PLL = full_reset(s_q.st);
	assign RST_SOFT_RESET_PRESERVED = full_reset(s_q.st);
	assign RST_HOST_BUS_IFACE = full_reset(s_q.st) || (s_q.st == rps_pkg::ST_SOFT_RESET_BIT);
	assign RST_MII = full_reset(s_q.st) || (s_q.st == rps_pkg::ST_SOFT_RESET_BIT);
	assign RST_MAC = full_reset(s_q.st) || (s_q.st == rps_pkg::ST_SOFT_RESET_BIT);
	assign RST_PHY = full_reset(s_q.st) || t_busy[rps_pkg::TMR_PHYR] || t_busy[rps_pkg::TMR_BCR]
		|| t_busy[rps_pkg::TMR_PDN];
	assign MAC_ADDR_RELOAD = s_q.reload;
	assign STRAP_LATCH = s_q.strap;

	// PHY power: energy-detect down keeps its state, no reset on wake
	assign PHY_POWERED = !PHY_POWER_DOWN && !ed_down;
	assign PHY_TX_EN = PHY_POWERED && !RST_PHY;
	assign ENERGY_PRESENT = s_q.en_lvl;
	assign ENERGY_IRQ_FLAG = s_q.irq_flag;
	assign HOST_IRQ = s_q.irq_flag && ENERGY_IRQ_EN;

endmodule

/* File: common/rps_pkg.sv */
// Package of constants and types shared by the reset and PHY power sequencer
package rps_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_KHZ = 200000; // 200 MHz system clock
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned POR_TIME_MS = 22; // Power-on hold time
	localparam int unsigned SOFT_RESET_BIT_TIME_NS = 2000; // Soft reset self-clear time
	localparam int unsigned PHY_RST_TIME_US = 100; // PHY reset self-clear time
	localparam int unsigned RESUME_TIME_NS = 1000; // Wake to ready, well under 2 ms
	localparam int unsigned EE_CHECK_TIME_NS = 5000; // EEPROM presence check time

	// Derived cycle counts; long ones are defaults of top parameters
	localparam int unsigned POR_CYCLES = POR_TIME_MS * CLK_KHZ;
	localparam int unsigned PHY_RST_CYCLES = PHY_RST_TIME_US * CLK_MHZ;
	localparam int unsigned SOFT_RESET_BIT_CYCLES = (SOFT_RESET_BIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RESUME_CYCLES = (RESUME_TIME_NS * CLK_MHZ) / 1000;
	localparam int unsigned EE_CHECK_CYCLES = (EE_CHECK_TIME_NS * CLK_MHZ + 999) / 1000;

	// ****************************************
	// Counter type and timer slots
	// ****************************************
	typedef logic [31:0] rps_cnt_t;
	localparam int TMR_NUM = 6;
	localparam int TMR_POR = 0; // Power-on hold
	localparam int TMR_SOFT_RESET_BIT = 1; // Soft reset
	localparam int TMR_PHYR = 2; // PHY reset from power control
	localparam int TMR_BCR = 3; // PHY reset from basic control
	localparam int TMR_PDN = 4; // PHY reset after general power-down
	localparam int TMR_WAKE = 5; // Resume from sleep
	localparam logic [2:0] SYNC_IDLE_HI = 3'h7; // Pulled-up pin idle pattern
	localparam logic [2:0] SYNC_IDLE_LO = 3'h0;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {ST_POR, ST_HWRST, ST_SOFT_RESET_BIT, ST_RUN, ST_SLEEP, ST_WAKE} rps_state_e;

endpackage

/* File: common/rps_tmr_if.sv */
// Interface carrying start, length and status of one sequencing timer
`timescale 1ns/10ps
interface rps_tmr_if;
	logic start;
	rps_pkg::rps_cnt_t cycles;
	logic busy;
	logic done;

	modport ctl (output start, output cycles, input busy, input done);
	modport tmr (input start, input cycles, output busy, output done);
endinterface

/* File: design/rps_timer.sv */
// One-shot cycle timer: busy for exactly the loaded number of cycles
`timescale 1ns/10ps
module rps_timer (
	input wire logic clk,
	input wire logic rst,
	rps_tmr_if.tmr t
);

	typedef struct packed {
		logic busy;
		rps_pkg::rps_cnt_t cnt;
	} rps_tmr_s;

	rps_tmr_s s_q;
	rps_tmr_s s_d;

	// A start reloads the count, even while already running
	always_comb begin
		s_d = s_q;
		if (t.start) begin
			s_d.busy = 1'b1;
			s_d.cnt = t.cycles;
		end else if (s_q.busy) begin
			s_d.cnt = rps_pkg::rps_cnt_t'(s_q.cnt - 32'h0000_0001);
			if (s_q.cnt <= 32'h0000_0001) begin
				s_d.busy = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Status toward the sequencer
	assign t.busy = s_q.busy;
	assign t.done = s_q.busy && (s_q.cnt == 32'h0000_0001) && !t.start;

endmodule

/* File: verification/rps_host_model.sv */
// Host processor model issuing register strobes and polling ready
`timescale 1ns/10ps
module rps_host_model (
	input wire logic CLK,
	input wire logic READY,
	input wire logic EEPROM_BUSY,
	input wire logic WRITE_ACCEPT,
	output logic HOST_READ,
	output logic HOST_WRITE,
	output logic SOFT_RESET_WR,
	output logic PHY_RESET_WR,
	output logic PHY_BCR_RESET_WR,
	output logic SLEEP_WR,
	output logic WAKE_WR
);
	logic [6:0] stb = 7'h00;
	logic w;
	// Strobe vector: bit 0 read, 1 write, 2 soft reset, 3 PHY, 4 PHY control, 5 sleep, 6 wake
	assign {WAKE_WR, SLEEP_WR, PHY_BCR_RESET_WR, PHY_RESET_WR, SOFT_RESET_WR, HOST_WRITE, HOST_READ} = stb;
	// One access held over one rising edge; the write answer is taken at that edge
	task automatic acc(input int k, output logic wa);
		@(negedge CLK);
		stb = 7'(1 << k);
		@(posedge CLK);
		wa = WRITE_ACCEPT;
		@(negedge CLK);
		stb = 7'h00;
	endtask
	// Poll ready with reads under a bound, then one more read to open writes
	task automatic wait_ready(input int lim, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < lim && ok !== 1'b1; i++) begin
			acc(0, w);
			ok = READY;
		end
		acc(0, w);
	endtask
	// Keep off the EEPROM and address until the check is over
	task automatic wait_idle(input int lim, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < lim && ok !== 1'b1; i++) begin
			@(negedge CLK);
			ok = !EEPROM_BUSY;
		end
	endtask
endmodule

/* File: verification/rps_checker.sv */
// Port-level timing checks of the reset sequencer
`timescale 1ns/10ps
module rps_checker #(
	parameter int unsigned PHY_RST_CYCLES = 20
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HW_RESET_IN_N,
	input wire logic HOST_WRITE,
	input wire logic PHY_RESET_WR,
	input wire logic WAKE_WR,
	input wire logic PHY_POWER_DOWN,
	input wire logic ED_POWER_DOWN_EN,
	input wire logic READY,
	input wire logic SOFT_RESET_BIT,
	input wire logic PHY_RESET_BIT,
	input wire logic EEPROM_BUSY,
	input wire logic WRITE_ACCEPT,
	input wire logic RST_PLL,
	input wire logic RST_MAC,
	input wire logic MAC_ADDR_RELOAD,
	input wire logic STRAP_LATCH,
	input wire logic PHY_POWERED,
	input wire logic PHY_TX_EN,
	input wire logic ENERGY_PRESENT
);
	logic [15:0] s_cnt_q, p_cnt_q;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// High-run length of the soft reset and PHY reset bits; a PHY write restarts the latter
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_cnt_q <= 16'h0000;
			p_cnt_q <= 16'h0000;
		end else begin
			s_cnt_q <= SOFT_RESET_BIT ? s_cnt_q + 16'h0001 : 16'h0000;
			p_cnt_q <= (PHY_RESET_BIT && !PHY_RESET_WR) ? p_cnt_q + 16'h0001 : 16'h0000;
		end
	end
	soft_reset_bit_domain_a: assert property (SOFT_RESET_BIT |-> !READY && RST_MAC && !RST_PLL)
		else $error("soft reset domains wrong");
	soft_reset_bit_len_a: assert property ($fell(SOFT_RESET_BIT) && !RST_PLL |-> s_cnt_q == 16'(rps_pkg::SOFT_RESET_BIT_CYCLES) && READY)
		else $error("soft reset length wrong");
	soft_reload_a: assert property ($fell(SOFT_RESET_BIT) && !RST_PLL |-> MAC_ADDR_RELOAD && !STRAP_LATCH)
		else $error("soft reset reload wrong");
	phy_len_a: assert property ($fell(PHY_RESET_BIT) && !RST_PLL |-> p_cnt_q == 16'(PHY_RST_CYCLES))
		else $error("phy reset length wrong");
	start_done_a: assert property (STRAP_LATCH |-> READY && MAC_ADDR_RELOAD && EEPROM_BUSY)
		else $error("reset completion wrong");
	pin_reset_a: assert property (!HW_RESET_IN_N [*6] |-> RST_PLL && !READY)
		else $error("pin reset not taken");
	write_gate_a: assert property (WRITE_ACCEPT |-> HOST_WRITE && READY)
		else $error("write taken while not ready");
	phy_pdown_a: assert property (PHY_POWER_DOWN || ED_POWER_DOWN_EN && !ENERGY_PRESENT |-> !PHY_POWERED && !PHY_TX_EN)
		else $error("phy not powered down");
	wake_ready_a: assert property (WAKE_WR && !READY && !RST_PLL && !SOFT_RESET_BIT |-> ##[1:400] READY)
		else $error("wake too slow");
endmodule
bind rps_top rps_checker #(.PHY_RST_CYCLES(PHY_RST_CYCLES)) i_chk (.*);

/* File: verification/test_reset_and_phy_power_control.sv */
// Self-checking testbench of the reset and PHY power sequencer
`timescale 1ns/10ps
module test_reset_and_phy_power_control;
	localparam int POR = 50;
	localparam int PHYR = 20;
	logic CLK = 1'b0, RST = 1'b1, HW_RESET_IN_N = 1'b1, PHY_POWER_DOWN = 1'b0;
	logic ED_POWER_DOWN_EN = 1'b0, LINE_ENERGY = 1'b0, ENERGY_IRQ_EN = 1'b0, ENERGY_IRQ_CLR = 1'b0;
	logic HOST_READ, HOST_WRITE, SOFT_RESET_WR, PHY_RESET_WR, PHY_BCR_RESET_WR, SLEEP_WR, WAKE_WR;
	logic READY, SOFT_RESET_BIT, PHY_RESET_BIT, PHY_BCR_RESET_BIT, EEPROM_BUSY, WRITE_ACCEPT, RST_PLL;
	logic RST_HOST_BUS_IFACE, RST_SOFT_RESET_PRESERVED, RST_MII, RST_MAC, RST_PHY, MAC_ADDR_RELOAD;
	logic STRAP_LATCH, PHY_POWERED, PHY_TX_EN, ENERGY_PRESENT, ENERGY_IRQ_FLAG, HOST_IRQ;
	logic armed = 1'b1, was = 1'b1, busy, w, ok, en;
	int mismatches = 0, tests_run = 0, seed = 69, cyc = 0, n = 0;
	int notes[$];
	rps_top #(.POR_CYCLES(POR), .PHY_RST_CYCLES(PHYR)) i_dut (.*);
	rps_host_model i_host (.*);
	// Clock
	always #2.5 CLK = ~CLK;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge CLK);
	endtask
	// Busy length since the last strobe, compared with the oldest note
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			n = 0;
			armed = 1'b1;
			was = 1'b1;
		end else begin
			busy = !READY || SOFT_RESET_BIT || PHY_RESET_BIT || PHY_BCR_RESET_BIT;
			if (SOFT_RESET_WR || PHY_RESET_WR || PHY_BCR_RESET_WR || SLEEP_WR || WAKE_WR) begin
				n = 0;
				armed = 1'b1;
			end else begin
				if (armed && was && !busy) begin
					check(n, notes.size() > 0 ? notes.pop_front() : -1);
					armed = 1'b0;
				end
				n++;
			end
			was = busy;
		end
	end
	// Hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 10000) begin
			mismatches++;
			complete_run;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(negedge CLK);
		notes.push_back(POR + 1);
		RST = 1'b0;
		i_host.wait_ready(100, ok);
		check(EEPROM_BUSY, 1);
		i_host.wait_idle(1100, ok);
		notes.push_back(400);
		i_host.acc(2, w);
		check(RST_PHY, 0);
		check(RST_MII, 1);
		check(RST_HOST_BUS_IFACE, 1);
		check(RST_SOFT_RESET_PRESERVED, 0);
		i_host.acc(1, w);
		check(w, 0);
		i_host.wait_ready(400, ok);
		check(EEPROM_BUSY, 1);
		i_host.wait_idle(1100, ok);
		check(ok, 1);
		notes.push_back(PHYR);
		i_host.acc(3, w);
		check(RST_PHY, 1);
		i_host.acc(3, w);
		idle(PHYR + 4);
		check(RST_PHY, 0);
		notes.push_back(PHYR);
		i_host.acc(4, w);
		check(RST_MAC, 0);
		idle(PHYR + 4);
		check(RST_PHY, 0);
		i_host.acc(5, w);
		i_host.acc(1, w);
		check(w, 0);
		notes.push_back(200);
		i_host.acc(6, w);
		idle(205);
		i_host.acc(1, w);
		check(w, 0);
		i_host.acc(0, w);
		i_host.acc(1, w);
		check(w, 1);
		en = 1'($random(seed));
		ENERGY_IRQ_EN = en;
		ED_POWER_DOWN_EN = 1'b1;
		idle(6);
		check(PHY_TX_EN, 0);
		LINE_ENERGY = 1'b1;
		idle(6);
		check(ENERGY_IRQ_FLAG, 1);
		check(HOST_IRQ, en);
		check(PHY_POWERED, 1);
		check(ENERGY_PRESENT, 1);
		ENERGY_IRQ_CLR = 1'b1;
		idle(1);
		ENERGY_IRQ_CLR = 1'b0;
		ED_POWER_DOWN_EN = 1'b0;
		LINE_ENERGY = 1'b0;
		idle(6);
		check(ENERGY_IRQ_FLAG, 0);
		check(PHY_POWERED, 1);
		PHY_POWER_DOWN = 1'b1;
		idle(3);
		PHY_POWER_DOWN = 1'b0;
		idle(4);
		check(RST_PHY, 1);
		idle(PHYR + 4);
		check(PHY_TX_EN, 1);
		HW_RESET_IN_N = 1'b0;
		idle(8);
		check(RST_PHY, 1);
		check(RST_SOFT_RESET_PRESERVED, 1);
		check(READY, 0);
		HW_RESET_IN_N = 1'b1;
		i_host.wait_ready(10, ok);
		check(ok, 1);
		check(EEPROM_BUSY, 1);
		check(notes.size(), 0);
		complete_run;
	end
endmodule
